// File: core/bcc_pkg.sv
package bcc_pkg;

  // ****************************************
  // Register map (indices on the plain port)
  // ****************************************
  localparam logic [2:0] ADDR_CTRL_A   = 3'h0;  // Boost control A
  localparam logic [2:0] ADDR_CTRL_B   = 3'h1;  // Boost control B
  localparam logic [2:0] ADDR_SUP_STAT = 3'h2;  // Supervisory status
  localparam logic [2:0] ADDR_STICKY   = 3'h3;  // Sticky status, clears on read

  // ****************************************
  // Field positions
  // ****************************************
  localparam int VCODE_LSB  = 0;  // Output-voltage code [4:0]
  localparam int VCODE_W    = 5;
  localparam int MODE_LSB   = 5;  // Operating mode [6:5]
  localparam int PULSE_BIT  = 7;  // Manual pulse request
  localparam int FSEL_LSB   = 0;  // Switching-frequency select [1:0]
  localparam int ENABLE_BIT = 3;  // Converter enable
  localparam int UV_STICKY_BIT = 0;

  // ****************************************
  // Encodings and reset values
  // ****************************************
  localparam logic [1:0] MODE_ACTIVE  = 2'h0;  // Any other code is standby
  localparam logic [1:0] MODE_STANDBY = 2'h1;
  localparam logic [1:0] FSEL_400K    = 2'h1;
  localparam logic [1:0] FSEL_EXT     = 2'h3;
  localparam logic [4:0] VCODE_1V8    = 5'h0_003;  // Code for 1.8 V output
  localparam logic [7:0] CTRL_A_RST   = {3'h0, VCODE_1V8};
  localparam logic [7:0] CTRL_B_RST   = 8'h0_009;  // Enabled, 400 kHz

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ      = 100;
  localparam int PULSE_NS     = 1000;  // Manual pulse width
  localparam int PULSE_CYC    = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int SW400_KHZ    = 400;
  localparam int SW400_HALF   = (CLK_MHZ * 1000) / (2 * SW400_KHZ);

  // Supervisory comparator bundle
  typedef struct packed {
    logic above_50;   // Output above nominal + 50 mV
    logic above_25;   // Output above nominal + 25 mV
    logic above_nom;  // Output above nominal
    logic below_25;   // Output below nominal - 25 mV
    logic below_50;   // Output below nominal - 50 mV
  } bcc_sup_t;

endpackage : bcc_pkg

// File: core/bcc_sync3.sv
`timescale 1ns/1ps
// ****************************************
// Three-stage synchroniser, change accepted when stages 2 and 3 agree
// ****************************************
module bcc_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_r;  // Metastability stage
  logic [W-1:0] s2_r;  // Second stage
  logic [W-1:0] s3_r;  // Third stage
  logic [W-1:0] q_r;   // Filtered value

  // Shift chain and agreement filter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          q_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign q = q_r;

endmodule : bcc_sync3

// File: core/bcc_top.sv
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
//
// Functional notes
// - Enable bit 3 of control B
// - Five-bit voltage code in control A
// - Reset: enabled, 1.8 V code
// - Single write always updates register
// - Control A bits 6:5 select mode
// - Frequency select: 01=400 kHz, 11=external
// - External rate from 32 kHz crystal
// - Switching clock synchronised before bus use
// - Standby keeps supervisory status live
// - Manual pulse bit gives 1 us pulse
// - Auto pulse on both crystal edges
// - Status bits 4..2 above thresholds
// - Status bits 1..0 below thresholds
// - Undervoltage raises power-manager interrupt
// - Undervoltage wake source, software enabled
// - Sticky undervoltage cleared by read
// - Hibernate forces active mode
//
module bcc_top #(
  parameter int PULSE_CYCLES = bcc_pkg::PULSE_CYC,
  parameter int HALF_400K    = bcc_pkg::SW400_HALF
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // Register port
  input  wire logic [2:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  // Analog side
  input  wire logic [4:0]       sup_cmp_in,
  input  wire logic             xtal_32k,
  input  wire logic             chip_hibernate,
  input  wire logic             wake_enable,
  output logic                  boost_en,
  output logic      [4:0]       boost_vcode,
  output logic                  boost_standby,
  output logic                  boost_switch,
  output logic                  boost_gate,
  // Power manager
  output logic                  pm_irq,
  output logic                  pm_wake
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]       ctrl_a_r;      // Control A
  logic [7:0]       ctrl_b_r;      // Control B
  logic             uv_sticky_r;   // Sticky undervoltage
  logic [7:0]       rdata_r;       // Read data, one cycle late
  logic [15:0]      pulse_cnt_r;   // Manual pulse countdown
  logic [15:0]      sw_cnt_r;      // 400 kHz divider
  logic             sw400_r;       // 400 kHz square wave
  logic             xtal_d_r;      // Previous synced crystal level
  logic             auto_pulse_r;  // Auto pulse active
  logic [15:0]      auto_cnt_r;    // Auto pulse countdown
  logic             sw_out_r;      // Registered switching clock
  logic             gate_r;        // Registered transistor gate
  logic             irq_r;         // Registered interrupt
  logic             wake_r;        // Registered wake
  logic             en_r;          // Registered enable
  logic [4:0]       vcode_r;       // Registered voltage code
  logic             stby_r;        // Registered standby

  // ****************************************
  // Synchronised inputs
  // ****************************************
  bcc_pkg::bcc_sup_t sup_s;        // Comparator levels in bus domain
  logic              xtal_s;       // Crystal level in bus domain

  bcc_sync3 #(.W(5)) u_sync_sup (
    .core_clk (core_clk),
    .rstn     (rstn),
    .d        (sup_cmp_in),
    .q        (sup_s)
  );

  bcc_sync3 #(.W(1)) u_sync_xtal (
    .core_clk (core_clk),
    .rstn     (rstn),
    .d        (xtal_32k),
    .q        (xtal_s)
  );

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
    hit = (a == r);
  endfunction : hit

  wire wr_a       = reg_wr && hit(reg_addr, bcc_pkg::ADDR_CTRL_A);
  wire wr_b       = reg_wr && hit(reg_addr, bcc_pkg::ADDR_CTRL_B);
  wire rd_sticky  = reg_rd && hit(reg_addr, bcc_pkg::ADDR_STICKY);
  wire [1:0] mode_f = ctrl_a_r[bcc_pkg::MODE_LSB +: 2];
  // Hibernate forces active; non-active codes mean standby
  wire standby    = (mode_f != bcc_pkg::MODE_ACTIVE) && !chip_hibernate;
  wire enabled    = ctrl_b_r[bcc_pkg::ENABLE_BIT];
  wire [1:0] fsel = ctrl_b_r[bcc_pkg::FSEL_LSB +: 2];
  wire below_cfg  = sup_s.below_25 || sup_s.below_50 || !sup_s.above_nom;
  wire xtal_edge  = xtal_s ^ xtal_d_r;
  wire auto_fire  = enabled && standby && below_cfg && xtal_edge;
  wire pulse_req  = wr_a && reg_wdata[bcc_pkg::PULSE_BIT];
  wire uv_event   = enabled && sup_s.below_50;
  wire sw_sel     = (fsel == bcc_pkg::FSEL_EXT) ? xtal_s :
                    (fsel == bcc_pkg::FSEL_400K) ? sw400_r : 1'b0;

  // Read mux; status is live in both modes
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      bcc_pkg::ADDR_CTRL_A:   rd_mux = ctrl_a_r;
      bcc_pkg::ADDR_CTRL_B:   rd_mux = ctrl_b_r;
      bcc_pkg::ADDR_SUP_STAT: rd_mux = {3'h0, sup_s};
      bcc_pkg::ADDR_STICKY:   rd_mux = {7'h0, uv_sticky_r};
      default:                rd_mux = 8'h0;
    endcase
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Pulse bit is self-clearing; stored value shows the running pulse
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_a_r <= bcc_pkg::CTRL_A_RST;
      ctrl_b_r <= bcc_pkg::CTRL_B_RST;
    end else begin
      if (wr_a) begin
        ctrl_a_r <= reg_wdata;
      end else begin
        ctrl_a_r[bcc_pkg::PULSE_BIT] <= (pulse_cnt_r > 16'h0_001);
      end
      if (wr_b) begin
        ctrl_b_r <= reg_wdata;
      end
    end
  end

  // Read data and sticky flag; a new event beats the read clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r     <= 8'h0;
      uv_sticky_r <= 1'b0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 8'h0;
      if (uv_event) begin
        uv_sticky_r <= 1'b1;
      end else if (rd_sticky) begin
        uv_sticky_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Pulse generation
  // ****************************************
  // Manual and automatic pulse timers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_cnt_r  <= 16'h0;
      auto_cnt_r   <= 16'h0;
      auto_pulse_r <= 1'b0;
      xtal_d_r     <= 1'b0;
    end else begin
      xtal_d_r <= xtal_s;
      if (pulse_req && enabled) begin
        pulse_cnt_r <= 16'(PULSE_CYCLES);
      end else if (pulse_cnt_r != 16'h0) begin
        pulse_cnt_r <= pulse_cnt_r - 16'h1;
      end
      if (auto_fire) begin
        auto_cnt_r   <= 16'(PULSE_CYCLES);
        auto_pulse_r <= 1'b1;
      end else if (auto_cnt_r != 16'h0) begin
        auto_cnt_r   <= auto_cnt_r - 16'h1;
        auto_pulse_r <= (auto_cnt_r > 16'h1);
      end
    end
  end

  // 400 kHz divider
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sw_cnt_r <= 16'h0;
      sw400_r  <= 1'b0;
    end else if (sw_cnt_r == 16'(HALF_400K - 1)) begin
      sw_cnt_r <= 16'h0;
      sw400_r  <= ~sw400_r;
    end else begin
      sw_cnt_r <= sw_cnt_r + 16'h1;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      en_r     <= 1'b0;
      vcode_r  <= 5'h0;
      stby_r   <= 1'b0;
      sw_out_r <= 1'b0;
      gate_r   <= 1'b0;
      irq_r    <= 1'b0;
      wake_r   <= 1'b0;
    end else begin
      en_r     <= enabled;
      vcode_r  <= ctrl_a_r[bcc_pkg::VCODE_LSB +: bcc_pkg::VCODE_W];
      stby_r   <= standby;
      sw_out_r <= enabled && !standby && sw_sel;
      gate_r   <= enabled && ((pulse_cnt_r != 16'h0) || auto_pulse_r);
      irq_r    <= uv_sticky_r;
      wake_r   <= uv_sticky_r && wake_enable;
    end
  end

  assign reg_rdata     = rdata_r;
  assign boost_en      = en_r;
  assign boost_vcode   = vcode_r;
  assign boost_standby = stby_r;
  assign boost_switch  = sw_out_r;
  assign boost_gate    = gate_r;
  assign pm_irq        = irq_r;
  assign pm_wake       = wake_r;

endmodule : bcc_top

// File: dv/bcc_top_assertions.sv
`timescale 1ns/1ps
// ****************************************
// Port checker for the boost control block
// ****************************************
module bcc_top_chk #(
  parameter int PULSE_CYCLES = 100
) (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rstn,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  // Analog side and power manager
  input wire logic [4:0] sup_cmp_in,
  input wire logic       chip_hibernate,
  input wire logic       wake_enable,
  input wire logic       boost_en,
  input wire logic [4:0] boost_vcode,
  input wire logic       boost_standby,
  input wire logic       boost_gate,
  input wire logic       pm_irq,
  input wire logic       pm_wake
);
  logic [15:0] gate_cnt_r;  // Cycles the gate has stood high
  wire logic   rd_sticky;   // Read that clears the sticky flag
  assign rd_sticky = reg_rd && (reg_addr == bcc_pkg::ADDR_STICKY);
  // Gate pulse length counter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gate_cnt_r <= 16'h0000;
    end else begin
      gate_cnt_r <= boost_gate ? gate_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Register writes
  sequence s_wr_a;
    reg_wr && (reg_addr == bcc_pkg::ADDR_CTRL_A);
  endsequence
  sequence s_wr_b;
    reg_wr && (reg_addr == bcc_pkg::ADDR_CTRL_B);
  endsequence
  a_en_follow: assert property (s_wr_b |-> ##2 boost_en == $past(reg_wdata[3], 2))
    else $error("enable output off");
  a_vcode_follow: assert property (s_wr_a |-> ##2 boost_vcode == $past(reg_wdata[4:0], 2))
    else $error("voltage code output off");
  a_mode_select: assert property ((!chip_hibernate)[*6] ##0 s_wr_a ##0 boost_en
    |-> ##2 boost_standby == ($past(reg_wdata[6:5], 2) != bcc_pkg::MODE_ACTIVE))
    else $error("standby output off");
  a_hib_active: assert property (chip_hibernate[*8] |-> !boost_standby)
    else $error("standby in hibernate");
  a_pulse_start: assert property (s_wr_a ##0 (reg_wdata[7] && boost_en && !boost_gate)
    |-> ##2 boost_gate)
    else $error("manual pulse missing");
  a_pulse_width: assert property ($fell(boost_gate) |-> gate_cnt_r == PULSE_CYCLES)
    else $error("gate pulse width wrong");
  a_uv_irq: assert property ((boost_en && sup_cmp_in[0])[*8] |-> pm_irq)
    else $error("undervoltage irq missing");
  a_sticky_hold: assert property (pm_irq && $past(!rd_sticky) |=> pm_irq)
    else $error("sticky flag lost");
  a_wake_gate: assert property ((!wake_enable)[*6] |-> !pm_wake)
    else $error("wake without enable");
endmodule : bcc_top_chk

bind bcc_top bcc_top_chk #(.PULSE_CYCLES(PULSE_CYCLES)) i_chk (
  .core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .sup_cmp_in,
  .chip_hibernate, .wake_enable, .boost_en, .boost_vcode, .boost_standby,
  .boost_gate, .pm_irq, .pm_wake
);

// File: dv/bcc_top_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) check_eq(16'(g), 16'(e));
module bcc_top_tb;
  localparam int PW = 20;  // Shortened pulse width
  localparam int HW = 10;  // Shortened 400 kHz half period
  logic core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic xtal_32k = 1'b0, chip_hibernate = 1'b0, wake_enable = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, rd_v, a_v, b_v;
  logic [4:0] sup_cmp_in = 5'h00;
  wire logic [7:0] reg_rdata;
  wire logic [4:0] boost_vcode;
  wire logic boost_en, boost_standby, boost_switch, boost_gate, pm_irq, pm_wake;
  logic sw_q = 1'b0;
  int err_total = 0, checked = 0, hi, sw, t;
  always #5 core_clk = ~core_clk;
  bcc_top #(.PULSE_CYCLES(PW), .HALF_400K(HW)) i_dut (
    .core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sup_cmp_in, .xtal_32k, .chip_hibernate, .wake_enable, .boost_en,
    .boost_vcode, .boost_standby, .boost_switch, .boost_gate, .pm_irq, .pm_wake
  );
  // Compare and count
  task automatic check_eq(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : check_eq
  // One-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  // Read strobe, data taken in the cycle after
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    v = reg_rdata;
  endtask : rd
  // Idle cycles, counting gate highs and switch edges
  task automatic run(input int m);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    hi = 0;
    sw = 0;
    repeat (m) begin
      @(posedge core_clk);
      hi += int'(boost_gate);
      sw += int'(boost_switch !== sw_q);
      sw_q = boost_switch;
    end
  endtask : run
  // Verdict
  task automatic results();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  // Watchdog
  initial begin
    #500us;
    err_total++;
    results();
  end
  // Main sequence
  initial begin
    void'($urandom(75));
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    run(2);
    `CHK(boost_en, 1'b1)
    `CHK(boost_vcode, bcc_pkg::VCODE_1V8)
    rd(bcc_pkg::ADDR_CTRL_A, rd_v);
    `CHK(rd_v, bcc_pkg::CTRL_A_RST)
    rd(bcc_pkg::ADDR_CTRL_B, rd_v);
    `CHK(rd_v, bcc_pkg::CTRL_B_RST)
    for (int i = 0; i < 16; i++) begin
      a_v = 8'($urandom) & 8'h7f;
      b_v = 8'($urandom);
      wr(bcc_pkg::ADDR_CTRL_A, a_v);
      wr(bcc_pkg::ADDR_CTRL_B, b_v);
      wr(3'h4 | 3'($urandom), 8'hff);
      // Paired reads run back to back, nothing can slip in between
      rd(bcc_pkg::ADDR_CTRL_A, rd_v);
      rd(bcc_pkg::ADDR_CTRL_A, rd_v);
      `CHK(rd_v, a_v)
      rd(bcc_pkg::ADDR_CTRL_B, rd_v);
      rd(bcc_pkg::ADDR_CTRL_B, rd_v);
      `CHK(rd_v, b_v)
      rd(3'h4 | 3'($urandom), rd_v);
      `CHK(rd_v, 8'h00)
      `CHK(boost_en, b_v[3])
      `CHK(boost_vcode, a_v[4:0])
      if (b_v[3])
        `CHK(boost_standby, a_v[6:5] != bcc_pkg::MODE_ACTIVE)
    end
    // Manual pulse enabled, then disabled
    for (int k = 0; k < 2; k++) begin
      wr(bcc_pkg::ADDR_CTRL_B, k ? 8'h01 : bcc_pkg::CTRL_B_RST);
      run(4);
      wr(bcc_pkg::ADDR_CTRL_A, 8'h80 | bcc_pkg::CTRL_A_RST);
      run(PW + 20);
      `CHK(hi, k ? 0 : PW)
    end
    wr(bcc_pkg::ADDR_CTRL_B, bcc_pkg::CTRL_B_RST);
    wr(bcc_pkg::ADDR_CTRL_A, 8'h20 | bcc_pkg::CTRL_A_RST);
    for (int i = 0; i < 8; i++) begin
      sup_cmp_in <= (i == 0) ? 5'h1f : 5'($urandom);
      run(8);
      rd(bcc_pkg::ADDR_SUP_STAT, rd_v);
      `CHK(rd_v[4:0], sup_cmp_in)
    end
    // Auto pulses on both crystal edges only when below nominal
    for (int k = 0; k < 2; k++) begin
      sup_cmp_in <= k ? 5'h04 : 5'h02;
      run(10);
      t = 0;
      repeat (4) begin
        xtal_32k <= ~xtal_32k;
        run(200);
        t += hi;
      end
      `CHK(t, k ? 0 : 4 * PW)
    end
    chip_hibernate <= 1'b1;
    run(10);
    `CHK(boost_standby, 1'b0)
    chip_hibernate <= 1'b0;
    wr(bcc_pkg::ADDR_CTRL_A, bcc_pkg::CTRL_A_RST);
    run(20);
    run(8 * HW);
    `CHK(sw, 8)
    wr(bcc_pkg::ADDR_CTRL_B, 8'h08 | bcc_pkg::FSEL_EXT);
    run(20);
    run(60);
    `CHK(sw, 0)
    xtal_32k <= ~xtal_32k;
    run(60);
    `CHK(sw != 0, 1'b1)
    // Sticky undervoltage, interrupt and wake
    wr(bcc_pkg::ADDR_CTRL_B, bcc_pkg::CTRL_B_RST);
    sup_cmp_in <= 5'h01;
    run(12);
    `CHK(pm_irq, 1'b1)
    wake_enable <= 1'b1;
    run(8);
    `CHK(pm_wake, 1'b1)
    sup_cmp_in <= 5'h04;
    run(8);
    rd(bcc_pkg::ADDR_STICKY, rd_v);
    `CHK(rd_v[0], 1'b1)
    rd(bcc_pkg::ADDR_STICKY, rd_v);
    `CHK(rd_v[0], 1'b0)
    rstn <= 1'b0;
    run(3);
    rstn <= 1'b1;
    run(2);
    `CHK(boost_vcode, bcc_pkg::VCODE_1V8)
    results();
  end
endmodule : bcc_top_tb
